/* bench/comparator_control_logic_sva.sv */
// port assertions for the comparator control block
`timescale 1ns/1ps
module comparator_control_checker (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic comp_level_in,
	input wire logic light_stop_in,
	input wire logic deep_stop_exit_in,
	input wire logic analog_enable_out,
	input wire logic reference_select_out,
	input wire logic output_pin_out,
	input wire logic output_pin_oe_out,
	input wire logic irq_out,
	input wire logic wake_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic ctl_wr;
	assign ctl_wr = reg_wr_in && reg_addr_in == 8'h00 && !deep_stop_exit_in;
	a_enable_follows: assert property (ctl_wr |=> analog_enable_out == $past(reg_wdata_in[7]))
		else $error("enable output wrong");
	a_refsel_follows: assert property (ctl_wr |=> reference_select_out == $past(reg_wdata_in[6]))
		else $error("reference select wrong");
	a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
		else $error("read data outside read slot");
	a_live_off: assert property (reg_rd_in && reg_addr_in == 8'h00 && !analog_enable_out |=> !reg_rdata_out[3])
		else $error("live bit set while off");
	a_pin_gated: assert property (!output_pin_oe_out |-> !output_pin_out)
		else $error("pin driven while not enabled");
	a_oe_needs_on: assert property (output_pin_oe_out |-> analog_enable_out || $past(analog_enable_out))
		else $error("pin enabled with module off");
	a_wake_cause: assert property (wake_out |-> light_stop_in && irq_out)
		else $error("wake without cause");
	a_irq_sticky: assert property (irq_out && !reg_wr_in && !deep_stop_exit_in |=> irq_out)
		else $error("interrupt dropped by itself");
	a_reset_quiet: assert property ($rose(rst_n_in) |-> !analog_enable_out && !irq_out && !output_pin_oe_out)
		else $error("outputs not clear after reset");
	a_deep_clear: assert property (deep_stop_exit_in |=> !analog_enable_out && !irq_out)
		else $error("state kept over deep stop");
endmodule
bind comparator_control_logic comparator_control_checker u_chk (.*);

/* bench/comparator_core_model.sv */
// behavioural analog comparator core at the far side
`timescale 1ns/1ps
module comparator_core_model (
	input wire logic enable_in,
	input wire logic ref_sel_in,
	input real plus_in,
	input real minus_in,
	input real ref_in,
	output logic level_out
);
	real noninv;
	always_comb begin
		noninv = ref_sel_in ? ref_in : plus_in;
		level_out = enable_in && (noninv > minus_in);
	end
endmodule

/* bench/tb_comparator_control_logic.sv */
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb_comparator_control_logic;
	logic clk_in, rst_n_in, reg_wr_in, reg_rd_in, light_stop_in, deep_stop_exit_in, comp_level_in;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, ctl;
	logic analog_enable_out, reference_select_out, output_pin_out, output_pin_oe_out, irq_out, wake_out;
	real plus_v, minus_v, ref_v;
	int failures, total_checks;
	comparator_control_logic DUT (.*);
	comparator_core_model core (.enable_in(analog_enable_out), .ref_sel_in(reference_select_out),
		.plus_in(plus_v), .minus_in(minus_v), .ref_in(ref_v), .level_out(comp_level_in));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	// ****************************************
	// bus tasks
	// ****************************************
	task cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 `CHK(reg_rdata_out, e)
	endtask
	// analog swing kept off the edge, then time for sync and flag
	task swing(input real p);
		#2 plus_v = p;
		cyc(6);
		#1;
	endtask
	task summarize;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#200000 failures++;
		summarize;
	end
	initial begin
		rst_n_in = 0; reg_wr_in = 0; reg_rd_in = 0; reg_addr_in = 0; reg_wdata_in = 0;
		light_stop_in = 0; deep_stop_exit_in = 0; failures = 0; total_checks = 0;
		plus_v = 1.0; minus_v = 2.0; ref_v = 3.0;
		cyc(3);
		rst_n_in <= 1'b1;
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		`CHK(irq_out, 1'b0)
		$display("test reset done");
		for (int m = 0; m < 4; m++) begin
			ctl = 8'h94 | m[7:0];
			wr(8'h00, ctl);
			cyc(4);
			swing(3.0);
			rd(8'h00, ctl | 8'h08 | (m % 2 == 1 ? 8'h20 : 8'h00));
			`CHK(irq_out, (m % 2 == 1))
			`CHK(output_pin_out, 1'b1)
			`CHK(output_pin_oe_out, 1'b1)
			wr(8'h00, ctl | 8'h20);
			swing(1.0);
			rd(8'h00, ctl | (m != 1 ? 8'h20 : 8'h00));
			wr(8'h00, ctl);
			rd(8'h00, ctl | (m != 1 ? 8'h20 : 8'h00));
			wr(8'h00, ctl | 8'h20);
			`CHK(irq_out, 1'b0)
		end
		$display("test edge modes done");
		rd(8'h01, 8'h07);
		wr(8'h02, 8'h04);
		`CHK(irq_out, 1'b1)
		rd(8'h02, 8'h04);
		wr(8'h03, 8'h04);
		`CHK(irq_out, 1'b0)
		wr(8'h01, 8'h00);
		rd(8'h01, 8'h03);
		rd(8'h10, 8'h00);
		wr(8'h03, 8'h07);
		wr(8'h02, 8'h00);
		$display("test interrupt registers done");
		wr(8'h00, 8'hc0);
		cyc(8);
		rd(8'h00, 8'hc8);
		`CHK(reference_select_out, 1'b1)
		`CHK(output_pin_oe_out, 1'b0)
		wr(8'h00, 8'h91);
		// low level from the reference switch must cross the sync first
		cyc(4);
		light_stop_in <= 1'b1;
		swing(3.0);
		`CHK(wake_out, 1'b1)
		`CHK(irq_out, 1'b1)
		cyc(1);
		light_stop_in <= 1'b0;
		wr(8'h00, 8'h11);
		`CHK(wake_out, 1'b0)
		rd(8'h00, 8'h31);
		`CHK(analog_enable_out, 1'b0)
		$display("test reference and stop done");
		@(posedge clk_in);
		deep_stop_exit_in <= 1'b1;
		@(posedge clk_in);
		deep_stop_exit_in <= 1'b0;
		rd(8'h00, 8'h00);
		`CHK(irq_out, 1'b0)
		$display("test deep stop done");
		summarize;
	end
endmodule

/* rtl/comparator_control_logic.sv */
// control and status logic around an analog comparator core
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "comparator_control_params.svh"

module comparator_control_logic (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic comp_level_in,
	input wire logic light_stop_in,
	input wire logic deep_stop_exit_in,
	output logic analog_enable_out,
	output logic reference_select_out,
	output logic output_pin_out,
	output logic output_pin_oe_out,
	output logic irq_out,
	output logic wake_out
);

	// ****************************************
	// helpers
	// ****************************************

	// does a transition match the chosen edge mode
	function automatic logic edge_match(
		input logic [1:0] mode,
		input logic rise,
		input logic fall
	);
		logic hit;
		hit = 1'b0;
		case (mode)
			`CMP_MODE_FALL0: begin
				hit = fall;
			end
			`CMP_MODE_RISE: begin
				hit = rise;
			end
			`CMP_MODE_FALL2: begin
				hit = fall;
			end
			`CMP_MODE_BOTH: begin
				hit = rise | fall;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction

	// register slot hit by a strobe, used by the write decode
	function automatic logic reg_hit(
		input logic strobe,
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		return strobe && (addr == ofs);
	endfunction

	// synchronised level as software and pin see it, low while off
	function automatic logic live_level(
		input comparator_control_pkg::state_type s
	);
		return s.module_enable_bit & s.sync_second;
	endfunction

	// pin driven only with the module on and its pin enable set
	function automatic logic pin_enabled(
		input comparator_control_pkg::state_type s
	);
		return s.module_enable_bit & s.output_pin_enable;
	endfunction

	// comparator event pending with its interrupt enabled
	function automatic logic event_pending(
		input comparator_control_pkg::state_type s
	);
		return s.compare_event_flag & s.event_interrupt_enable;
	endfunction

	// any enabled bit of the status block
	function automatic logic status_pending(
		input comparator_control_pkg::state_type s
	);
		return |(s.irq_status & s.irq_enable);
	endfunction

	// status/control byte as software sees it
	function automatic logic [7:0] control_byte(
		input comparator_control_pkg::state_type s
	);
		logic [7:0] b;
		b = `CMP_RST_BYTE;
		b[`CMP_BIT_ENABLE] = s.module_enable_bit;
		b[`CMP_BIT_REF_SEL] = s.reference_select_bit;
		b[`CMP_BIT_FLAG] = s.compare_event_flag;
		b[`CMP_BIT_IE] = s.event_interrupt_enable;
		b[`CMP_BIT_LIVE] = live_level(s);
		b[`CMP_BIT_OPE] = s.output_pin_enable;
		b[`CMP_MODE_HI:`CMP_MODE_LO] = s.edge_mode_field;
		return b;
	endfunction

	// widen the three interrupt bits to a byte
	function automatic logic [7:0] irq_byte(
		input logic [2:0] bits
	);
		logic [7:0] b;
		b = `CMP_RST_BYTE;
		b[`CMP_IRQ_W-1:0] = bits;
		return b;
	endfunction

	// read mux: write-only and unmapped slots read as zero
	function automatic logic [7:0] read_byte(
		input comparator_control_pkg::state_type s,
		input logic [7:0] addr
	);
		logic [7:0] b;
		b = `CMP_RST_BYTE;
		case (addr)
			`CMP_OFS_CONTROL: begin
				b = control_byte(s);
			end
			`CMP_OFS_IRQ_STATUS: begin
				b = irq_byte(s.irq_status);
			end
			`CMP_OFS_IRQ_ENABLE: begin
				b = irq_byte(s.irq_enable);
			end
			default: begin
				b = `CMP_RST_BYTE;
			end
		endcase
		return b;
	endfunction

	// cleared block, shared by reset and the return from deep stop
	function automatic comparator_control_pkg::state_type reset_state();
		comparator_control_pkg::state_type s;
		s = '0;
		s.arm = comparator_control_pkg::ARM_OFF;
		return s;
	endfunction

	// ****************************************
	// state
	// ****************************************
	comparator_control_pkg::state_type state_q;
	comparator_control_pkg::state_type state_d;
	comparator_control_pkg::bus_req_type req;
	logic rise;
	logic fall;
	logic event_hit;
	logic flag_clear;
	logic [2:0] irq_set;
	logic [2:0] irq_clear;
	logic ctl_wr;
	logic ien_wr;
	logic clr_wr;

	// ****************************************
	// register decode
	// ****************************************

	assign req = '{
		addr: reg_addr_in,
		wdata: reg_wdata_in,
		wr: reg_wr_in,
		rd: reg_rd_in
	};

	assign ctl_wr = reg_hit(req.wr, req.addr, `CMP_OFS_CONTROL);
	assign ien_wr = reg_hit(req.wr, req.addr, `CMP_OFS_IRQ_ENABLE);
	assign clr_wr = reg_hit(req.wr, req.addr, `CMP_OFS_IRQ_CLEAR);

	// ****************************************
	// edge detection
	// ****************************************

	// the comparator core already gives high for plus above minus
	// edges are only taken once the pipeline holds two fresh samples
	always_comb begin
		rise = 1'b0;
		fall = 1'b0;
		if (state_q.arm == comparator_control_pkg::ARM_READY) begin
			rise = state_q.sync_second & ~state_q.level_prev;
			fall = ~state_q.sync_second & state_q.level_prev;
		end
	end

	// light stop needs no gating here: the clock keeps running
	assign event_hit = edge_match(state_q.edge_mode_field, rise, fall);

	// ****************************************
	// write decode
	// ****************************************
	always_comb begin
		flag_clear = 1'b0;
		irq_clear = `CMP_RST_IRQ;
		if (ctl_wr) begin
			flag_clear = req.wdata[`CMP_BIT_FLAG];
		end
		if (clr_wr) begin
			irq_clear = req.wdata[`CMP_IRQ_W-1:0];
		end
	end

	// ****************************************
	// interrupt status sources
	// ****************************************

	always_comb begin
		irq_set = `CMP_RST_IRQ;
		irq_set[`CMP_IRQ_EVENT] = event_hit;
		irq_set[`CMP_IRQ_RISE] = rise;
		irq_set[`CMP_IRQ_FALL] = fall;
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		state_d = state_q;

		// two-stage crossing of the analog level
		state_d.sync_first = comp_level_in;
		state_d.sync_second = state_q.sync_first;
		state_d.level_prev = state_q.sync_second;

		// settle after enable so a high level is not seen as a rising edge
		case (state_q.arm)
			comparator_control_pkg::ARM_OFF: begin
				if (state_q.module_enable_bit) begin
					state_d.arm = comparator_control_pkg::ARM_SETTLE1;
				end
			end
			comparator_control_pkg::ARM_SETTLE1: begin
				state_d.arm = comparator_control_pkg::ARM_SETTLE2;
			end
			comparator_control_pkg::ARM_SETTLE2: begin
				state_d.arm = comparator_control_pkg::ARM_READY;
			end
			comparator_control_pkg::ARM_READY: begin
				state_d.arm = comparator_control_pkg::ARM_READY;
			end
			default: begin
				state_d.arm = comparator_control_pkg::ARM_OFF;
			end
		endcase

		// disabled: pipeline held at zero, nothing detected
		if (!state_q.module_enable_bit) begin
			state_d.sync_first = 1'b0;
			state_d.sync_second = 1'b0;
			state_d.level_prev = 1'b0;
			state_d.arm = comparator_control_pkg::ARM_OFF;
		end

		// control register write
		if (ctl_wr) begin
			state_d.module_enable_bit = req.wdata[`CMP_BIT_ENABLE];
			state_d.reference_select_bit = req.wdata[`CMP_BIT_REF_SEL];
			state_d.event_interrupt_enable = req.wdata[`CMP_BIT_IE];
			state_d.output_pin_enable = req.wdata[`CMP_BIT_OPE];
			state_d.edge_mode_field = req.wdata[`CMP_MODE_HI:`CMP_MODE_LO];
		end

		// set wins over a clear in the same cycle
		if (flag_clear) begin
			state_d.compare_event_flag = 1'b0;
		end
		if (event_hit) begin
			state_d.compare_event_flag = 1'b1;
		end

		// interrupt block registers
		if (ien_wr) begin
			state_d.irq_enable = req.wdata[`CMP_IRQ_W-1:0];
		end
		state_d.irq_status = (state_q.irq_status & ~irq_clear) | irq_set;

		// pin follows the synchronised level, enable gates it
		state_d.pin_oe = pin_enabled(state_q);
		state_d.pin_level = pin_enabled(state_q) & live_level(state_q);

		// read data stand one cycle after the strobe, zero otherwise
		state_d.rdata = `CMP_RST_BYTE;
		if (req.rd) begin
			state_d.rdata = read_byte(state_q, req.addr);
		end

		// return from deep stop puts the whole block back to reset
		if (deep_stop_exit_in) begin
			state_d = reset_state();
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q <= reset_state();
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign reg_rdata_out = state_q.rdata;
	assign analog_enable_out = state_q.module_enable_bit;
	assign reference_select_out = state_q.reference_select_bit;
	assign output_pin_out = state_q.pin_level;
	assign output_pin_oe_out = state_q.pin_oe;

	// interrupt: comparator event path plus the masked status block
	assign irq_out = event_pending(state_q) | status_pending(state_q);

	// wake request only matters while the core sleeps
	assign wake_out = light_stop_in & event_pending(state_q);

endmodule

/* rtl/comparator_control_params.svh */
// register offsets, field positions and reset values of the comparator control block
`ifndef COMPARATOR_CONTROL_PARAMS_SVH
`define COMPARATOR_CONTROL_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define CMP_ADDR_W 8
`define CMP_DATA_W 8
`define CMP_OFS_CONTROL 8'h00
`define CMP_OFS_IRQ_STATUS 8'h01
`define CMP_OFS_IRQ_ENABLE 8'h02
`define CMP_OFS_IRQ_CLEAR 8'h03

// ****************************************
// control register fields
// ****************************************
`define CMP_BIT_ENABLE 7
`define CMP_BIT_REF_SEL 6
`define CMP_BIT_FLAG 5
`define CMP_BIT_IE 4
`define CMP_BIT_LIVE 3
`define CMP_BIT_OPE 2
`define CMP_MODE_HI 1
`define CMP_MODE_LO 0

// ****************************************
// edge mode encodings
// ****************************************
`define CMP_MODE_FALL0 2'h0
`define CMP_MODE_RISE 2'h1
`define CMP_MODE_FALL2 2'h2
`define CMP_MODE_BOTH 2'h3

// ****************************************
// interrupt status bits
// ****************************************
`define CMP_IRQ_W 3
`define CMP_IRQ_EVENT 0
`define CMP_IRQ_RISE 1
`define CMP_IRQ_FALL 2

// ****************************************
// reset values
// ****************************************
`define CMP_RST_BYTE 8'h00
`define CMP_RST_IRQ 3'h0
`define CMP_RST_MODE 2'h0

`endif

/* rtl/comparator_control_pkg.sv */
// types shared by the comparator control block
package comparator_control_pkg;

	// ****************************************
	// settling sequence after enable
	// ****************************************
	typedef enum logic [1:0] {
		ARM_OFF,
		ARM_SETTLE1,
		ARM_SETTLE2,
		ARM_READY
	} arm_state_type;

	// ****************************************
	// register bus request
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_type;

	// ****************************************
	// whole block state
	// ****************************************
	typedef struct packed {
		logic module_enable_bit;
		logic reference_select_bit;
		logic compare_event_flag;
		logic event_interrupt_enable;
		logic output_pin_enable;
		logic [1:0] edge_mode_field;
		logic sync_first;
		logic sync_second;
		logic level_prev;
		arm_state_type arm;
		logic pin_level;
		logic pin_oe;
		logic [2:0] irq_status;
		logic [2:0] irq_enable;
		logic [7:0] rdata;
	} state_type;

endpackage
